// *** pio_ports.sv ***
// Push-pull, open-drain and analog-shared port logic with an APB register slave
//
// Decided for this implementation: register access over APB.
`include "pio_consts.svh"
`default_nettype none
module pio_ports #(
   parameter int ADDR_W = 12,
   parameter int PP_W = 8,
   parameter int OD_W = 6,
   parameter int AN_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [PP_W-1:0] pp_pin_i,
   output logic [PP_W-1:0] pp_pin_o,
   output logic [PP_W-1:0] pp_pin_oe,
   input wire logic [OD_W-1:0] od_pin_i,
   output logic [OD_W-1:0] od_pin_o,
   output logic [OD_W-1:0] od_pin_oe,
   input wire logic [AN_W-1:0] an_pin_i,
   output logic [AN_W-1:0] an_pin_o,
   output logic [AN_W-1:0] an_pin_oe,
   input wire logic [1:0] timer_en,
   input wire logic [1:0] timer_out,
   input wire logic [OD_W-1:0] serial_oe,
   input wire logic [OD_W-1:0] serial_out,
   output logic [PP_W-1:0] pp_in,
   output logic [OD_W-1:0] od_in,
   output logic [AN_W-1:0] an_in
);

   // ==========================================================
   // Declarations
   pio_pkg::pio_bus_e bus_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [9:0] idx;
   logic hit;
   logic wr_ok;
   logic [7:0] rd_val;
   logic [PP_W-1:0] pp_lat;
   logic [PP_W-1:0] pp_dir_q;
   logic [OD_W-1:0] od_lat_q;
   logic [AN_W-1:0] an_lat;
   logic [AN_W-1:0] an_dir_q;
   pio_pkg::pio_stby_s stby_q;
   logic [PP_W-1:0] pp_tmr_en;
   logic [PP_W-1:0] pp_tmr_val;
   logic [PP_W-1:0] pp_flt;
   logic [PP_W-1:0] pp_oe_d;
   logic [PP_W-1:0] pp_o_d;
   logic [PP_W-1:0] pp_lvl;
   logic [PP_W-1:0] pp_in_d;
   logic [OD_W-1:0] od_oe_d;
   logic [OD_W-1:0] od_lvl;
   logic [OD_W-1:0] od_in_d;
   logic [AN_W-1:0] an_oe_d;
   logic [AN_W-1:0] an_o_d;
   logic [AN_W-1:0] an_lvl;
   logic [AN_W-1:0] an_in_d;
   logic [PP_W-1:0] pp_nofloat;

   assign pp_nofloat = `PIO_PP_NOFLOAT_MASK;

   // ==========================================================
   // APB slave
   // Word index of the access
   assign idx = paddr[11:2];

   // Address decode
   always_comb
   begin
      unique case (idx)
         `PIO_IDX_PP_DATA, `PIO_IDX_PP_DIR, `PIO_IDX_OD_DATA,
         `PIO_IDX_PP_BSET, `PIO_IDX_PP_BCLR, `PIO_IDX_OD_BSET,
         `PIO_IDX_OD_BCLR, `PIO_IDX_AN_DATA, `PIO_IDX_AN_DIR,
         `PIO_IDX_STBY: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Write takes effect at the completing access edge
   assign wr_ok = psel && penable && pready_q && pwrite && !pslverr_q;

   // One wait-free answer: pready high in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_q <= pio_pkg::PIO_BUS_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         unique case (bus_q)
            pio_pkg::PIO_BUS_IDLE:
            begin
               if (psel && !penable)
               begin
                  bus_q <= pio_pkg::PIO_BUS_ACC;
                  pready_q <= 1'b1;
                  pslverr_q <= !hit;
               end
            end
            pio_pkg::PIO_BUS_ACC:
            begin
               bus_q <= pio_pkg::PIO_BUS_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
            end
         endcase
      end
   end

   // Read value of each register
   always_comb
   begin
      rd_val = 8'h00;
      unique case (idx)
         `PIO_IDX_PP_DATA: rd_val = pp_lvl; // RL4 RL9
         `PIO_IDX_PP_DIR: rd_val = pp_dir_q; // RL2
         `PIO_IDX_OD_DATA: rd_val = {2'h0, od_lvl}; // RL14
         `PIO_IDX_AN_DATA: rd_val = an_lvl;
         `PIO_IDX_AN_DIR: rd_val = an_dir_q;
         `PIO_IDX_STBY: rd_val = {5'h00, stby_q.float_act, stby_q.standby_pin_float_select, stby_q.mode};
         default: rd_val = 8'h00;
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite && bus_q == pio_pkg::PIO_BUS_IDLE)
         prdata_q <= {24'h00_0000, rd_val};
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ==========================================================
   // Registers
   // Push-pull latch, not reset
   always_ff @(posedge pclk)
   begin
      if (wr_ok && idx == `PIO_IDX_PP_DATA)
         pp_lat <= pwdata[PP_W-1:0]; // RL6 RL7 RL3
      else if (wr_ok && idx == `PIO_IDX_PP_BSET)
         pp_lat <= pp_lat | pwdata[PP_W-1:0]; // RL5
      else if (wr_ok && idx == `PIO_IDX_PP_BCLR)
         pp_lat <= pp_lat & ~pwdata[PP_W-1:0]; // RL5
   end

   // Push-pull direction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pp_dir_q <= `PIO_PP_DIR_RST; // RL10
      else if (wr_ok && idx == `PIO_IDX_PP_DIR)
         pp_dir_q <= pwdata[PP_W-1:0]; // RL2
   end

   // Open-drain latch, all released at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         od_lat_q <= `PIO_OD_DATA_RST; // RL17
      else if (wr_ok && idx == `PIO_IDX_OD_DATA)
         od_lat_q <= pwdata[OD_W-1:0]; // RL15
      else if (wr_ok && idx == `PIO_IDX_OD_BSET)
         od_lat_q <= od_lat_q | pwdata[OD_W-1:0]; // RL5
      else if (wr_ok && idx == `PIO_IDX_OD_BCLR)
         od_lat_q <= od_lat_q & ~pwdata[OD_W-1:0]; // RL5
   end

   // Analog-shared port latch, not reset
   always_ff @(posedge pclk)
   begin
      if (wr_ok && idx == `PIO_IDX_AN_DATA)
         an_lat <= pwdata[AN_W-1:0];
   end

   // Analog-shared port direction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         an_dir_q <= `PIO_AN_DIR_RST;
      else if (wr_ok && idx == `PIO_IDX_AN_DIR)
         an_dir_q <= pwdata[AN_W-1:0];
   end

   // Standby control; float select is sampled on entry only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stby_q <= '0;
      else if (wr_ok && idx == `PIO_IDX_STBY)
      begin
         stby_q.mode <= pwdata[`PIO_STBY_MODE_BIT];
         stby_q.standby_pin_float_select <= pwdata[`PIO_STBY_SPL_BIT];
         if (!pwdata[`PIO_STBY_MODE_BIT])
            stby_q.float_act <= 1'b0; // RL20
         else if (!stby_q.mode)
            stby_q.float_act <= pwdata[`PIO_STBY_SPL_BIT]; // RL1 RL12 RL19
      end
   end

   // ==========================================================
   // Pin logic
   // Timer outputs mapped onto their shared pins
   always_comb
   begin
      pp_tmr_en = '0;
      pp_tmr_val = '0;
      pp_tmr_en[`PIO_TMR0_PIN] = timer_en[0]; // RL8
      pp_tmr_val[`PIO_TMR0_PIN] = timer_out[0];
      pp_tmr_en[`PIO_TMR1_PIN] = timer_en[1]; // RL8
      pp_tmr_val[`PIO_TMR1_PIN] = timer_out[1];
   end

   // Standby float, timer pins excluded
   assign pp_flt = {PP_W{stby_q.float_act}} & ~pp_nofloat; // RL13

   // Push-pull per pin
   genvar gi;
   generate
      for (gi = 0; gi < PP_W; gi++)
      begin : g_pp
         assign pp_oe_d[gi] = pp_tmr_en[gi] | (pp_dir_q[gi] & !pp_flt[gi]); // RL2 RL8 RL12
         assign pp_o_d[gi] = pp_tmr_en[gi] ? pp_tmr_val[gi] :
                             (pp_oe_d[gi] ? pp_lat[gi] : 1'b0); // RL6 RL7
         assign pp_in_d[gi] = pp_flt[gi] ? `PIO_IN_FIXED : pp_pin_i[gi]; // RL20
         assign pp_lvl[gi] = pp_tmr_en[gi] ? pp_tmr_val[gi] :
                             (pp_flt[gi] ? `PIO_IN_FIXED :
                             (pp_dir_q[gi] ? pp_lat[gi] : pp_pin_i[gi])); // RL4 RL9
      end
   endgenerate

   // Open-drain per pin: driver on means pin pulled low
   generate
      for (gi = 0; gi < OD_W; gi++)
      begin : g_od
         assign od_oe_d[gi] = !stby_q.float_act &&
                              (serial_oe[gi] ? !serial_out[gi] : !od_lat_q[gi]); // RL15 RL18 RL19
         assign od_in_d[gi] = stby_q.float_act ? `PIO_IN_FIXED : od_pin_i[gi]; // RL19 RL20
         assign od_lvl[gi] = od_in_d[gi];
      end
   endgenerate

   // Analog-shared port per pin
   generate
      for (gi = 0; gi < AN_W; gi++)
      begin : g_an
         assign an_oe_d[gi] = an_dir_q[gi] & !stby_q.float_act; // RL1
         assign an_o_d[gi] = an_oe_d[gi] ? an_lat[gi] : 1'b0;
         assign an_in_d[gi] = stby_q.float_act ? `PIO_IN_FIXED : an_pin_i[gi]; // RL1 RL20
         assign an_lvl[gi] = stby_q.float_act ? `PIO_IN_FIXED :
                             (an_dir_q[gi] ? an_lat[gi] : an_pin_i[gi]);
      end
   endgenerate

   // Registered pin drivers and inward levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pp_pin_o <= '0;
         pp_pin_oe <= '0; // RL10
         od_pin_o <= '0;
         od_pin_oe <= '0; // RL17
         an_pin_o <= '0;
         an_pin_oe <= '0;
         pp_in <= '0;
         od_in <= '0;
         an_in <= '0;
      end
      else
      begin
         pp_pin_o <= pp_o_d;
         pp_pin_oe <= pp_oe_d;
         od_pin_o <= '0;
         od_pin_oe <= od_oe_d;
         an_pin_o <= an_o_d;
         an_pin_oe <= an_oe_d;
         pp_in <= pp_in_d;
         od_in <= od_in_d;
         an_in <= an_in_d;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Standby entry with float selected
   sequence s_float_entry;
      $rose(stby_q.float_act);
   endsequence

   // Setup cycle of a read of the push-pull data
   sequence s_pp_read_setup;
      psel && !penable && !pwrite && idx == `PIO_IDX_PP_DATA &&
      bus_q == pio_pkg::PIO_BUS_IDLE;
   endsequence

   // Every setup gets exactly one ready cycle
   AST_APB_READY: assert property ((psel && !penable && bus_q == pio_pkg::PIO_BUS_IDLE)
      |=> pready_q ##1 !pready_q)
      else $error("ready not answered in one cycle");
   // Output enables follow direction when no override
   AST_PP_DIR_DRIVE: assert property ((!stby_q.float_act && pp_tmr_en == '0)
      |=> pp_pin_oe == $past(pp_dir_q)) // RL2
      else $error("push-pull enable differs from direction");
   // Output pins drive latch written two edges earlier
   AST_PP_WRITE_OUT: assert property ((wr_ok && idx == `PIO_IDX_PP_DATA && !stby_q.float_act)
      |-> ##2 ((pp_pin_o ^ $past(pwdata[7:0], 2)) & $past(pp_dir_q) &
      ~$past(pp_tmr_en)) == 8'h00) // RL6
      else $error("output pin does not show written latch");
   // Input pins stay undriven after a data write
   AST_PP_WRITE_IN: assert property ((wr_ok && idx == `PIO_IDX_PP_DATA &&
      pp_dir_q == 8'h00 && pp_tmr_en == '0) ##1 (pp_dir_q == 8'h00 && pp_tmr_en == '0)
      |=> pp_pin_oe == 8'h00) // RL7
      else $error("input pin driven after data write");
   // Bit set leaves unselected latch bits alone
   AST_PP_BSET: assert property ((wr_ok && idx == `PIO_IDX_PP_BSET)
      |=> (pp_lat & ~$past(pwdata[7:0])) == ($past(pp_lat) & ~$past(pwdata[7:0]))) // RL5
      else $error("bit set disturbed other latch bits");
   // Timer override on its pin
   AST_TMR_DRIVE: assert property (timer_en[0]
      |=> pp_pin_oe[0] && pp_pin_o[0] == $past(timer_out[0])) // RL8
      else $error("timer output not on shared pin");
   // Read returns the timer output
   AST_TMR_READ: assert property ((s_pp_read_setup ##0 timer_en[1])
      |=> prdata_q[3] == $past(timer_out[1])) // RL9
      else $error("read does not return timer value");
   // Float entry releases all non-timer pins
   AST_FLOAT_PINS: assert property (s_float_entry
      |=> (pp_pin_oe & ~pp_nofloat) == '0 && od_pin_oe == '0 && an_pin_oe == '0) // RL12 RL19 RL1
      else $error("pins still driven in standby float");
   // Float never touches enabled timer pins
   AST_FLOAT_TMR: assert property ((stby_q.float_act && timer_en == 2'b11)
      |=> pp_pin_oe[0] && pp_pin_oe[3]) // RL13
      else $error("timer pin floated by standby");
   // Open-drain follows latch inverted without serial use
   AST_OD_LATCH: assert property ((!stby_q.float_act && serial_oe == '0)
      |=> od_pin_oe == ~$past(od_lat_q)) // RL15
      else $error("open-drain driver differs from latch");
   // Serial output owns every pin it enables
   AST_OD_SERIAL: assert property (!stby_q.float_act
      |=> ((od_pin_oe ^ ~$past(serial_out)) & $past(serial_oe)) == 6'h00) // RL18
      else $error("serial output not controlling pin");
   // Open-drain and analog inward levels fixed while floated
   AST_IN_FIXED: assert property (stby_q.float_act [*2]
      |-> od_in == {OD_W{`PIO_IN_FIXED}} && an_in == {AN_W{`PIO_IN_FIXED}}) // RL20
      else $error("inputs not fixed during standby float");
endmodule // pio_ports
`default_nettype wire

// *** pio_consts.svh ***
// Constants for the push-pull, open-drain and analog-shared port block
//
// Contract
// RL1: Standby float with select set blocks analog port inputs and floats its pins.
// RL2: Push-pull direction bit 1 makes output, 0 input; reads back the direction.
// RL3: Bit n of push-pull data and direction registers controls pin n.
// RL4: Normal push-pull data read returns live pin levels, latch for outputs.
// RL5: Bit set and bit clear act on the latch, other bits unchanged.
// RL6: Push-pull data write loads latch; output pins drive it at once.
// RL7: Data write to input pins only updates latch; driver stays off.
// RL8: Enabled timer output drives its shared pin, bits 0 and 3, overriding port.
// RL9: Reading data while timer drives a pin returns the timer output value.
// RL10: Reset clears push-pull direction to zero; data latch is not reset.
// RL11: Software writes latch data first, then sets the direction bit.
// RL12: Standby float with select set floats push-pull pins and blocks inputs.
// RL13: Timer-output pins 0 and 3 are never floated by standby select.
// RL14: Open-drain port has six pins on bits 0 to 5; bits 6, 7 unimplemented.
// RL15: Open-drain data 1 releases the pin, 0 pulls it low.
// RL16: Software selects port function in bridge select registers before use.
// RL17: Reset sets every open-drain latch bit to 1, all drivers off.
// RL18: Enabled serial output controls the open-drain pin; latch has no effect.
// RL19: Standby float with select set turns open-drain drivers off, inputs fixed.
// RL20: Blocked inputs feed a constant level inward; normal pins resume afterwards.
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
// Register indices, byte address is four times the index
`define PIO_IDX_PP_DATA 10'h004
`define PIO_IDX_PP_DIR 10'h006
`define PIO_IDX_OD_DATA 10'h020
`define PIO_IDX_PP_BSET 10'h008
`define PIO_IDX_PP_BCLR 10'h009
`define PIO_IDX_OD_BSET 10'h022
`define PIO_IDX_OD_BCLR 10'h023
`define PIO_IDX_AN_DATA 10'h030
`define PIO_IDX_AN_DIR 10'h031
`define PIO_IDX_STBY 10'h032
// Reset values and field positions
`define PIO_PP_DIR_RST 8'h00
`define PIO_AN_DIR_RST 8'h00
`define PIO_OD_DATA_RST 6'h3f
`define PIO_STBY_MODE_BIT 0
`define PIO_STBY_SPL_BIT 1
`define PIO_TMR0_PIN 3'h0
`define PIO_TMR1_PIN 3'h3
`define PIO_PP_NOFLOAT_MASK 8'h09
`define PIO_IN_FIXED 1'b0
`endif

// *** pio_pkg.sv ***
// Types shared by the port block
`default_nettype none
package pio_pkg;
   // One-hot APB slave phase
   typedef enum logic [1:0] {
      PIO_BUS_IDLE = 2'b01,
      PIO_BUS_ACC = 2'b10
   } pio_bus_e;
   // Standby control state
   typedef struct packed {
      logic float_act;
      logic standby_pin_float_select;
      logic mode;
   } pio_stby_s;
endpackage
`default_nettype wire

// *** pio_pin_model.sv ***
// Pin-side partner model for the port block
`default_nettype none
module pio_pin_model (
   input wire logic [7:0] pp_pin_o,
   input wire logic [7:0] pp_pin_oe,
   input wire logic [5:0] od_pin_oe,
   input wire logic [7:0] an_pin_o,
   input wire logic [7:0] an_pin_oe,
   input wire logic [7:0] ext_lvl,
   output logic [7:0] pp_pin_i,
   output logic [5:0] od_pin_i,
   output logic [7:0] an_pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Pin levels
   // Undriven push-pull pins follow the outside driver
   assign pp_pin_i = (pp_pin_o & pp_pin_oe) | (ext_lvl & ~pp_pin_oe);
   // Undriven analog pins see the opposite outside pattern
   assign an_pin_i = (an_pin_o & an_pin_oe) | (~ext_lvl & ~an_pin_oe);
   // Pull-up on open-drain lines, low while pulled down
   assign od_pin_i = ~od_pin_oe;
endmodule // pio_pin_model
`default_nettype wire

// *** pio_ports_tb.sv ***
// Self-checking testbench for the port block
`default_nettype none
module pio_ports_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pp_pin_i, pp_pin_o, pp_pin_oe, an_pin_i, an_pin_o, an_pin_oe;
   logic [7:0] pp_in, an_in, ext_lvl;
   logic [5:0] od_pin_i, od_pin_o, od_pin_oe, od_in, serial_oe, serial_out;
   logic [1:0] timer_en, timer_out;
   int err_count;
   int total_checks;
   // ==========================================================
   // Design and pin partner
   pio_ports i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pp_pin_i(pp_pin_i), .pp_pin_o(pp_pin_o), .pp_pin_oe(pp_pin_oe),
      .od_pin_i(od_pin_i), .od_pin_o(od_pin_o), .od_pin_oe(od_pin_oe), .an_pin_i(an_pin_i),
      .an_pin_o(an_pin_o), .an_pin_oe(an_pin_oe), .timer_en(timer_en),
      .timer_out(timer_out), .serial_oe(serial_oe), .serial_out(serial_out),
      .pp_in(pp_in), .od_in(od_in), .an_in(an_in));
   pio_pin_model i_pins (.pp_pin_o(pp_pin_o), .pp_pin_oe(pp_pin_oe),
      .od_pin_oe(od_pin_oe), .an_pin_o(an_pin_o), .an_pin_oe(an_pin_oe),
      .ext_lvl(ext_lvl), .pp_pin_i(pp_pin_i), .od_pin_i(od_pin_i), .an_pin_i(an_pin_i));
   // ==========================================================
   // Tasks
   // Verdict and end of run
   task automatic print_verdict();
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1)
      begin
         err_count++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read and compare
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Let registered pins follow
   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask
   // ==========================================================
   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Main sequence
   initial
   begin
      err_count = 0;
      total_checks = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {timer_en, timer_out, serial_oe, serial_out} = '0;
      ext_lvl = 8'h3c;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(pp_pin_oe, 32'h0);
      chk(od_pin_oe, 32'h0);
      rdc(12'h018, 32'h0);
      rdc(12'h080, 32'h3f);
      // Latch first, then direction
      apb(1'b1, 12'h010, 32'ha5);
      apb(1'b1, 12'h018, 32'hf0);
      settle();
      chk(pp_pin_oe, 32'hf0);
      chk(pp_pin_o[7:4], 32'ha);
      rdc(12'h018, 32'hf0);
      rdc(12'h010, 32'hac);
      apb(1'b1, 12'h010, 32'h5a);
      settle();
      chk(pp_pin_o[7:4], 32'h5);
      chk(pp_pin_oe, 32'hf0);
      // Bit set and clear act on latch while low pins are inputs
      apb(1'b1, 12'h020, 32'h01);
      apb(1'b1, 12'h024, 32'h10);
      apb(1'b1, 12'h018, 32'hff);
      settle();
      chk(pp_pin_o, 32'h4b);
      // Timers take pins 0 and 3 over the port
      @(posedge pclk);
      timer_en <= 2'b11;
      apb(1'b1, 12'h018, 32'h00);
      settle();
      chk(pp_pin_oe, 32'h09);
      chk(pp_pin_o & 8'h09, 32'h0);
      rdc(12'h010, 32'h34);
      apb(1'b1, 12'h018, 32'hff);
      // Open-drain data and serial override
      apb(1'b1, 12'h080, 32'h2a);
      settle();
      chk(od_pin_oe, 32'h15);
      chk(od_pin_o, 32'h0);
      rdc(12'h080, 32'h2a);
      @(posedge pclk);
      serial_oe <= 6'h21;
      serial_out <= 6'h21;
      settle();
      chk(od_pin_oe, 32'h14);
      @(posedge pclk);
      serial_oe <= 6'h00;
      // Open-drain bit set and clear act on the latch
      apb(1'b1, 12'h088, 32'h01);
      apb(1'b1, 12'h08c, 32'h08);
      settle();
      chk(od_pin_oe, 32'h1c);
      apb(1'b1, 12'h080, 32'h00);
      apb(1'b1, 12'h0c4, 32'hff);
      apb(1'b1, 12'h0c0, 32'h5c);
      // Standby with float select, then back to normal
      apb(1'b1, 12'h0c8, 32'h03);
      settle();
      chk(pp_pin_oe, 32'h09);
      chk(od_pin_oe, 32'h0);
      chk(an_pin_oe, 32'h0);
      chk({pp_in & 8'hf6, od_in, an_in}, 32'h0);
      rdc(12'h0c8, 32'h07);
      apb(1'b1, 12'h0c8, 32'h00);
      settle();
      chk(od_pin_oe, 32'h3f);
      chk(an_pin_oe, 32'hff);
      chk(pp_in, 32'h42);
      chk(an_pin_o, 32'h5c);
      chk(an_in, 32'h5c);
      rdc(12'h0c0, 32'h5c);
      // Standby without float select keeps pins working
      apb(1'b1, 12'h0c8, 32'h01);
      settle();
      chk(an_pin_oe, 32'hff);
      chk(od_pin_oe, 32'h3f);
      rdc(12'h0c8, 32'h01);
      // Unmapped place is refused
      apb(1'b1, 12'h3fc, 32'h55);
      chk(err, 32'h1);
      rdc(12'h3fc, 32'h0);
      print_verdict();
   end
endmodule // pio_ports_tb
`default_nettype wire
